// ==== pies_entry_sequencer.sv ====
/*
  Current state word register and the hardware interrupt entry sequence.
  Assumes an execution unit that starts an instruction only while execGo is
  high, a main storage port that acknowledges each request with a one-cycle
  memAck, and I/O channels that write their own codes into low storage.
*/
// The register addresses and the Avalon-MM interface to the registers were decided locally.
// Contract
// - Key in bits 20-23 selects protection, relocation.
// - Bits 28-31 give four independent mode flags.
// - Simulation mode hands interrupts to microprogram.
// - Escape mode checks as key zero.
// - Monitor mode requests analysis before each instruction.
// - Trace mode writes branch entries to storage.
// - Bits 32-33 hold instruction length in halfwords.
// - Bits 36-39 gate four program exceptions.
// - Bits 34-35 hold results code for branches.
// - Bits 40-63 hold next instruction address.
// - Taken branch overwrites instruction address.
// - Finish or cut instruction before entry.
// - Priority accepts; masked-zero requests may drop.
// - Processor code in bits 24-31; channels write theirs.
// - Store current word, address made relative.
// - Read new word, clear length code.
// - Fetch relocation by new key, make absolute.
// - Resample requests after entry, repeat or resume.
// - Maskable level needs its system mask bit.
// - Fixed priority picks among enabled levels.
`timescale 1ns/1ps
`default_nettype none
module pies_entry_sequencer
  import pies_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire pies_exec_t execRep,
  input wire logic [NLVL-1:0] irqReq,
  input wire logic [0:63] memRdata,
  input wire logic memAck,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output pies_mem_t memOut,
  output logic execGo,
  output logic endEarly,
  output logic simTrap,
  output logic [3:0] simLevel,
  output logic [3:0] protKey,
  output logic [3:0] relocKey,
  output logic [23:0] relocValue,
  output logic monitorMode,
  output logic traceMode
);
  // Every flip-flop of the block lives in this one record.
  typedef struct packed {
    pies_st_t st;
    logic [0:63] stw;
    logic [23:0] reloc;
    logic [3:0] lvl;
    logic pxPend;
    logic monPend;
    logic [7:0] code;
    logic relInstr;
    logic [0:63] newWord;
    logic [23:0] tracePtr;
    logic [23:0] brFrom;
    pies_mem_t mem;
    logic go;
    logic early;
    logic simTrap;
    logic [3:0] simLvl;
    logic [3:0] protKey;
    logic avWait;
    logic [31:0] avData;
  } pies_state_t;

  localparam pies_state_t RESET_VAL = '{st: ST_RUN, avWait: 1'b1, go: 1'b1, default: '0};

  pies_state_t q_ff; // Registered state.
  pies_state_t nxt_q; // Next state.
  logic [NLVL-1:0] req; // Raw request per level.
  logic [NLVL-1:0] en; // Request gated by its mask.
  logic anyEn; // Some enabled request is present.
  logic [3:0] pick; // Highest priority enabled level.
  logic [31:0] rdMux; // Register read value.
  logic pxIn; // Program exception raised this cycle.

  // Per level request source and mask gate.
  genvar g;
  for (g = 0; g < NLVL; g++) begin : g_lvl
    if (g == LVL_PX) begin : g_px
      assign req[g] = q_ff.pxPend;
    end else if (g == LVL_PA) begin : g_pa
      assign req[g] = q_ff.monPend;
    end else begin : g_ext
      assign req[g] = irqReq[g];
    end
    assign en[g] = req[g] & ((LVL_MASKBIT[g] == MASK_NONE) | q_ff.stw[LVL_MASKBIT[g]]);
  end

  always_comb begin
    pick = 4'h0;
    for (int i = NLVL - 1; i >= 0; i--) begin
      if (en[i]) begin
        pick = i[3:0];
      end
    end
  end
  assign anyEn = |en;

  assign pxIn = execRep.done & (execRep.pxReq | |(execRep.pgmExc & q_ff.stw[SW_PM_LO:SW_PM_HI]));

  // Register read multiplexer; unmapped offsets read zero.
  always_comb begin
    case (avs_address)
      REG_CTRL: rdMux = {30'h00000000, q_ff.relInstr, 1'b0};
      REG_NEWHI: rdMux = q_ff.newWord[0:31];
      REG_NEWLO: rdMux = q_ff.newWord[32:63];
      REG_SWHI: rdMux = q_ff.stw[0:31];
      REG_SWLO: rdMux = q_ff.stw[32:63];
      REG_STAT: rdMux = {24'h000000, q_ff.go, q_ff.lvl, q_ff.st};
      REG_TRACE: rdMux = {8'h00, q_ff.tracePtr};
      REG_RELOC: rdMux = {8'h00, q_ff.reloc};
      default: rdMux = 32'h00000000;
    endcase
  end

  // Sequencer, state word updates and bus slave in one next-state process.
  always_comb begin
    nxt_q = q_ff;
    nxt_q.simTrap = 1'b0;
    case (q_ff.st)
      ST_RUN: begin
        if (execRep.done) begin
          nxt_q.go = 1'b0;
          nxt_q.code = execRep.code;
          nxt_q.stw[SW_LEN_LO:SW_LEN_HI] = (execRep.kind == END_COMPLETE) ? 2'h0 : execRep.len;
          nxt_q.stw[SW_IA_LO:SW_IA_HI] = q_ff.stw[SW_IA_LO:SW_IA_HI] + {21'h000000, execRep.len, 1'b0};
          if (execRep.brTaken) begin
            nxt_q.stw[SW_IA_LO:SW_IA_HI] = execRep.target;
          end
          if (execRep.condWe && execRep.kind != END_SUPPRESS) begin
            nxt_q.stw[SW_COND_LO:SW_COND_HI] = execRep.condCode;
          end
          if (q_ff.stw[SW_MON]) begin
            nxt_q.monPend = 1'b1;
          end
          nxt_q.st = ST_DECIDE;
          if (execRep.brTaken && q_ff.stw[SW_TRC]) begin
            nxt_q.mem = '{req: 1'b1, we: 1'b1, be: BE_ALL, addr: q_ff.tracePtr,
                          wdata: {8'h00, q_ff.stw[SW_IA_LO:SW_IA_HI], 8'h00, execRep.target}};
            nxt_q.st = ST_TRACE;
          end
        end
      end
      ST_TRACE: begin
        if (memAck) begin
          nxt_q.mem.req = 1'b0;
          nxt_q.tracePtr = q_ff.tracePtr + TRACE_STEP;
          nxt_q.st = ST_DECIDE;
        end
      end
      ST_DECIDE: begin
        if (!anyEn) begin
          nxt_q.go = 1'b1;
          nxt_q.st = ST_RUN;
        end else if (q_ff.stw[SW_SIM]) begin
          nxt_q.simTrap = 1'b1;
          nxt_q.simLvl = pick;
          nxt_q.go = 1'b1;
          nxt_q.st = ST_RUN;
          if (pick == LVL_PX) begin
            nxt_q.pxPend = 1'b0;
          end
          if (pick == LVL_PA) begin
            nxt_q.monPend = 1'b0;
          end
        end else begin
          // accepted level, lower program exception dropped
          nxt_q.lvl = pick;
          if (pick == LVL_PX || pick == LVL_MC) begin
            nxt_q.pxPend = 1'b0;
          end
          if (pick == LVL_PA) begin
            nxt_q.monPend = 1'b0;
          end
          if (pick < LVL_IO0) begin
            nxt_q.stw[SW_MX_LO:SW_MX_HI] = (pick == LVL_PA) ? MON_CODE : q_ff.code;
          end
          if (q_ff.relInstr) begin
            nxt_q.stw[SW_IA_LO:SW_IA_HI] = q_ff.stw[SW_IA_LO:SW_IA_HI] - q_ff.reloc;
          end
          nxt_q.mem = '{req: 1'b1, we: 1'b1, be: (pick < LVL_IO0) ? BE_ALL : BE_NO_MX,
                        addr: OLD_BASE + {16'h0000, pick, 4'h0}, wdata: nxt_q.stw};
          nxt_q.st = ST_STORE;
        end
      end
      ST_STORE: begin
        if (memAck) begin
          nxt_q.mem.we = 1'b0;
          nxt_q.mem.addr = OLD_BASE + {16'h0000, q_ff.lvl, 4'h0} + NEW_OFS;
          nxt_q.st = ST_LOADNEW;
        end
      end
      ST_LOADNEW: begin
        if (memAck) begin
          nxt_q.stw = memRdata;
          nxt_q.stw[SW_LEN_LO:SW_LEN_HI] = 2'h0;
          nxt_q.mem.addr = RELOC_BASE + {17'h00000, memRdata[SW_KEY_LO:SW_KEY_HI], 3'h0};
          nxt_q.st = ST_LOADREL;
        end
      end
      ST_LOADREL: begin
        if (memAck) begin
          nxt_q.mem.req = 1'b0;
          nxt_q.reloc = memRdata[SW_IA_LO:SW_IA_HI];
          if (q_ff.relInstr) begin
            nxt_q.stw[SW_IA_LO:SW_IA_HI] = q_ff.stw[SW_IA_LO:SW_IA_HI] + memRdata[SW_IA_LO:SW_IA_HI];
          end
          nxt_q.st = ST_DECIDE;
        end
      end
      default: begin
        nxt_q.st = ST_RUN;
      end
    endcase

    // Bus slave: capture on the first cycle, answer on the second.
    if (q_ff.avWait) begin
      if (avs_read || avs_write) begin
        nxt_q.avWait = 1'b0;
        nxt_q.avData = rdMux;
      end
    end else begin
      nxt_q.avWait = 1'b1;
      if (avs_write) begin
        case (avs_address)
          REG_CTRL: begin
            nxt_q.relInstr = avs_writedata[CTRL_REL];
            // A load only starts between instructions, else it is ignored.
            if (avs_writedata[CTRL_LOAD] && q_ff.st == ST_RUN && !execRep.done) begin
              nxt_q.stw = q_ff.newWord;
              nxt_q.stw[SW_LEN_LO:SW_LEN_HI] = 2'h0;
              nxt_q.monPend = q_ff.newWord[SW_MON];
              nxt_q.go = 1'b0;
              nxt_q.mem = '{req: 1'b1, we: 1'b0, be: BE_ALL, wdata: '0,
                            addr: RELOC_BASE + {17'h00000, q_ff.newWord[SW_KEY_LO:SW_KEY_HI], 3'h0}};
              nxt_q.st = ST_LOADREL;
            end
          end
          REG_NEWHI: nxt_q.newWord[0:31] = avs_writedata;
          REG_NEWLO: nxt_q.newWord[32:63] = avs_writedata;
          REG_TRACE: nxt_q.tracePtr = avs_writedata[23:0];
          default: begin
          end
        endcase
      end
    end

    // A fresh exception sets its flag even in the cycle it is cleared.
    if (pxIn) begin
      nxt_q.pxPend = 1'b1;
    end
    // ask for early end on cutting levels
    nxt_q.early = en[LVL_MC] | en[LVL_PX];
    // escape mode checks with key zero
    nxt_q.protKey = nxt_q.stw[SW_ESC] ? 4'h0 : nxt_q.stw[SW_KEY_LO:SW_KEY_HI];
  end

  // Single register for the whole state record.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q_ff <= RESET_VAL;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // Outputs taken straight from the state record.
  assign avs_readdata = q_ff.avData;
  assign avs_waitrequest = q_ff.avWait;
  assign memOut = q_ff.mem;
  assign execGo = q_ff.go;
  assign endEarly = q_ff.early;
  assign simTrap = q_ff.simTrap;
  assign simLevel = q_ff.simLvl;
  assign protKey = q_ff.protKey;
  assign relocKey = q_ff.stw[SW_KEY_LO:SW_KEY_HI];
  assign relocValue = q_ff.reloc;
  assign monitorMode = q_ff.stw[SW_MON];
  assign traceMode = q_ff.stw[SW_TRC];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_protKey;
    protKey == (q_ff.stw[SW_ESC] ? 4'h0 : q_ff.stw[SW_KEY_LO:SW_KEY_HI]);
  endproperty
  a_protKey: assert property (p_protKey) else $error("protection key wrong");
  property p_store;
    (q_ff.st == ST_DECIDE && anyEn && !q_ff.stw[SW_SIM])
      |=> memOut.req && memOut.we && memOut.addr == OLD_BASE + {16'h0000, $past(pick), 4'h0};
  endproperty
  a_store: assert property (p_store) else $error("old word not stored");
  property p_order;
    (q_ff.st == ST_STORE && memAck) |=> q_ff.st == ST_LOADNEW && !memOut.we;
  endproperty
  a_order: assert property (p_order) else $error("new word read missing");
  property p_lenClear;
    (q_ff.st == ST_LOADNEW && memAck) |=> q_ff.stw[SW_LEN_LO:SW_LEN_HI] == 2'h0 ##1 q_ff.st == ST_LOADREL;
  endproperty
  a_lenClear: assert property (p_lenClear) else $error("length code not cleared");
  property p_reloc;
    (q_ff.st == ST_LOADREL && memAck) |=> relocValue == $past(memRdata[SW_IA_LO:SW_IA_HI]);
  endproperty
  a_reloc: assert property (p_reloc) else $error("relocation not loaded");
  // The sequencer leaves the run state for at least one cycle after every report.
  // It is one cycle when no trace entry is written and nothing is enabled or simulation mode takes the request, so the check is on leaving the state.
  property p_hold;
    (q_ff.st == ST_RUN && execRep.done) |=> !execGo && q_ff.st != ST_RUN;
  endproperty
  a_hold: assert property (p_hold) else $error("next instruction not held");
  property p_resume;
    (q_ff.st == ST_DECIDE && !anyEn) |=> execGo && q_ff.st == ST_RUN;
  endproperty
  a_resume: assert property (p_resume) else $error("no resume after entry");
  property p_branch;
    (q_ff.st == ST_RUN && execRep.done && execRep.brTaken) |=> q_ff.stw[SW_IA_LO:SW_IA_HI] == $past(execRep.target);
  endproperty
  a_branch: assert property (p_branch) else $error("branch target lost");
  property p_sim;
    (q_ff.st == ST_DECIDE && anyEn && q_ff.stw[SW_SIM]) |=> simTrap && q_ff.st == ST_RUN;
  endproperty
  a_sim: assert property (p_sim) else $error("simulation trap missing");
  property p_avAnswer;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_avAnswer: assert property (p_avAnswer) else $error("bus answer too long");
  c_entry: cover property (q_ff.st == ST_LOADREL && memAck);
  c_trace: cover property (q_ff.st == ST_TRACE && memAck);
  c_sim: cover property (simTrap);
  // An entry that converted the address to relative and back.
  c_relative: cover property (q_ff.st == ST_LOADREL && memAck && q_ff.relInstr);
  // An enabled machine check or program exception asking for an early end.
  c_early: cover property (endEarly);
endmodule
`default_nettype wire

// ==== pies_entry_sequencer_bench.sv ====
/*
  Self-checking bench for the interrupt entry sequencer.
  Assumes pies_storage_model as the storage side and a 25 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pies_entry_sequencer_bench
  import pies_pkg::*;
;
  logic clk;
  logic nrst;
  pies_exec_t execRep;
  logic [NLVL-1:0] irqReq;
  logic [0:63] memRdata;
  logic memAck;
  logic [4:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  pies_mem_t memOut;
  logic execGo, endEarly, simTrap, monitorMode, traceMode;
  logic [3:0] simLevel, protKey, relocKey, delay;
  logic [23:0] relocValue;
  // Last read data and a scratch state word.
  logic [31:0] rd;
  logic [0:63] w;
  pies_exec_t r;
  int error_cnt = 0;
  int check_count = 0;
  int simSeen = 0;
  int earlySeen = 0;
  logic [3:0] simLvlSeen;

  pies_entry_sequencer u_dut (.clk(clk), .nrst(nrst), .execRep(execRep), .irqReq(irqReq),
    .memRdata(memRdata), .memAck(memAck), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .memOut(memOut), .execGo(execGo), .endEarly(endEarly),
    .simTrap(simTrap), .simLevel(simLevel), .protKey(protKey), .relocKey(relocKey),
    .relocValue(relocValue), .monitorMode(monitorMode), .traceMode(traceMode));
  pies_storage_model u_mem (.clk(clk), .nrst(nrst), .memOut(memOut), .delay(delay),
    .memRdata(memRdata), .memAck(memAck));

  // The trap and the early-end request are short pulses, so a watcher counts them.
  always @(posedge clk) begin
    if (simTrap === 1'b1) begin
      simSeen++;
      simLvlSeen = simLevel;
    end
    if (endEarly === 1'b1) begin
      earlySeen++;
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("Checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // A bound ran out; count it and close the run.
  task automatic expire();
    error_cnt++;
    results();
  endtask

  // One Avalon access; the request stands until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 20) expire();
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Loads a new state word through the registers.
  task automatic ld(input logic [0:63] v);
    v[24:27] = 4'h0;
    bus(1'b1, REG_NEWHI, v[0:31]);
    bus(1'b1, REG_NEWLO, v[32:63]);
    bus(1'b1, REG_CTRL, 32'h1);
  endtask

  // Reports one finished instruction once execution is allowed.
  task automatic fin(input pies_exec_t x);
    int n;
    for (n = 0; n < 60; n++) begin
      @(posedge clk);
      if (execGo === 1'b1) break;
    end
    if (n == 60) expire();
    x.done = 1'b1;
    execRep <= x;
    @(posedge clk);
    execRep.done <= 1'b0;
  endtask

  // Waits until execution may go on and storage is quiet.
  task automatic waitGo();
    int n;
    for (n = 0; n < 80; n++) begin
      @(posedge clk);
      if (execGo === 1'b1 && memOut.req === 1'b0) break;
    end
    if (n == 80) expire();
  endtask

  task automatic t_reset();
    chk(avs_waitrequest, 1'b1);
    chk(execGo, 1'b1);
    bus(1'b0, REG_SWLO, 32'h0);
    chk(rd, 32'h0);
    $display("reset test done");
  endtask

  task automatic t_fields();
    w = '0;
    w[20:23] = 4'h5;
    w[29] = 1'b1;
    w[31] = 1'b1;
    ld(w);
    bus(1'b0, REG_SWHI, 32'h0);
    chk(rd, w[0:31]);
    chk(relocKey, 4'h5);
    chk(protKey, 4'h0);
    chk({monitorMode, traceMode}, 2'b01);
    w[29] = 1'b0;
    w[31] = 1'b0;
    ld(w);
    // The load edge is still settling when the bus task returns.
    waitGo();
    chk({protKey, traceMode}, {4'h5, 1'b0});
    $display("field test done");
  endtask

  // A taken branch under trace writes one table entry.
  task automatic t_branch();
    logic [31:0] p;
    w = '0;
    w[31] = 1'b1;
    ld(w);
    bus(1'b0, REG_TRACE, 32'h0);
    p = rd;
    u_mem.accLog.delete();
    r = '0;
    r.condWe = 1'b1;
    r.condCode = 2'h2;
    r.brTaken = 1'b1;
    r.target = 24'h000800;
    fin(r);
    waitGo();
    chk(u_mem.accLog.size(), 1);
    chk(u_mem.accLog[0], {1'b1, p[23:0]});
    chk(u_mem.mem[p[23:0]][40:63], 24'h000800);
    bus(1'b0, REG_SWLO, 32'h0);
    chk(rd[29:28], 2'h2);
    chk(rd[23:0], 24'h000800);
    bus(1'b0, REG_TRACE, 32'h0);
    chk(rd, p + 32'h8);
    $display("branch test done");
  endtask

  // Levels 6 and 7 together, slow storage, relative addresses; level 6 must win.
  task automatic t_entry();
    w = '0;
    w[4] = 1'b1;
    w[5] = 1'b1;
    u_mem.mem[24'h200] = 64'h0000000000000100;
    ld(w);
    // Requests wait until the load has finished, else it would take them.
    waitGo();
    bus(1'b1, REG_CTRL, 32'h2);
    u_mem.mem[24'h160] = 64'h0000005a00000000;
    u_mem.mem[24'h168] = 64'h00000200c0001000;
    u_mem.mem[24'h210] = 64'h0000000000000abc;
    u_mem.accLog.delete();
    delay <= 4'h3;
    irqReq <= 15'h00c0;
    r = '0;
    r.brTaken = 1'b1;
    r.target = 24'h000340;
    fin(r);
    waitGo();
    irqReq <= '0;
    chk(u_mem.accLog.size(), 3);
    chk(u_mem.accLog[0], {1'b1, 24'h000160});
    chk(u_mem.accLog[1], {1'b0, 24'h000168});
    chk(u_mem.accLog[2], {1'b0, 24'h000210});
    chk(u_mem.mem[24'h160][24:31], 8'h5a);
    chk(u_mem.mem[24'h160][40:63], 24'h000240);
    chk(u_mem.mem[24'h160][4], 1'b1);
    chk({relocKey, relocValue}, {4'h2, 24'h000abc});
    bus(1'b0, REG_SWLO, 32'h0);
    chk(rd[31:30], 2'h0);
    chk(rd[23:0], 24'h001abc);
    $display("entry test done");
  endtask

  // The new word left level 6 masked, so nothing may start.
  task automatic t_masked();
    delay <= 4'h0;
    u_mem.accLog.delete();
    irqReq <= 15'h0040;
    fin('0);
    waitGo();
    chk(u_mem.accLog.size(), 0);
    irqReq <= '0;
    $display("mask test done");
  endtask

  task automatic t_sim();
    w = '0;
    w[4] = 1'b1;
    w[28] = 1'b1;
    ld(w);
    waitGo();
    u_mem.accLog.delete();
    irqReq <= 15'h0040;
    fin('0);
    waitGo();
    irqReq <= '0;
    repeat (4) @(posedge clk);
    chk(simSeen != 0, 1'b1);
    chk(simLvlSeen, 4'h6);
    chk(u_mem.accLog.size(), 0);
    ld('0);
    $display("simulation test done");
  endtask

  // The load itself raises the analysis request, so entry follows the load.
  task automatic t_monitor();
    u_mem.mem[24'h138] = 64'h0;
    waitGo();
    u_mem.accLog.delete();
    w = '0;
    w[30] = 1'b1;
    ld(w);
    waitGo();
    chk(u_mem.accLog[1], {1'b1, 24'h000130});
    chk(u_mem.mem[24'h130][24:31], MON_CODE);
    // The new word has monitor mode off, so no further entry.
    fin('0);
    waitGo();
    chk(u_mem.accLog.size(), 4);
    $display("monitor test done");
  endtask

  // Overflow first with its program mask bit clear, then set.
  task automatic t_pgm();
    u_mem.mem[24'h118] = 64'h0;
    w = '0;
    w[0] = 1'b1;
    ld(w);
    waitGo();
    u_mem.accLog.delete();
    r = '0;
    r.pgmExc = 4'b1000;
    fin(r);
    waitGo();
    chk(u_mem.accLog.size(), 0);
    chk(earlySeen, 0);
    w[36] = 1'b1;
    ld(w);
    waitGo();
    u_mem.accLog.delete();
    r.kind = END_SUPPRESS;
    r.len = 2'h2;
    fin(r);
    waitGo();
    chk(u_mem.accLog[0], {1'b1, 24'h000110});
    chk(u_mem.mem[24'h110][32:33], 2'h2);
    chk(earlySeen != 0, 1'b1);
    $display("program exception test done");
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    nrst = 1'b0;
    execRep = '0;
    irqReq = '0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    delay = 4'h0;
    u_mem.mem[24'h200] = 64'h0;
    // Relocation slot of key 5, used by the field test.
    u_mem.mem[24'h228] = 64'h0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset();
    t_fields();
    t_branch();
    t_entry();
    t_masked();
    t_sim();
    t_monitor();
    t_pgm();
    results();
  end
endmodule
`default_nettype wire

// ==== pies_pkg.sv ====
/*
  Shared constants and carrier types for the interrupt entry sequencer.
  Assumes one processor clock; state word bit 0 is the most significant bit.
*/
`default_nettype none
package pies_pkg;
  // State word field positions.
  localparam int SW_KEY_LO = 20;
  localparam int SW_KEY_HI = 23;
  localparam int SW_MX_LO = 24;
  localparam int SW_MX_HI = 31;
  localparam int SW_SIM = 28;
  localparam int SW_ESC = 29;
  localparam int SW_MON = 30;
  localparam int SW_TRC = 31;
  localparam int SW_LEN_LO = 32;
  localparam int SW_LEN_HI = 33;
  localparam int SW_COND_LO = 34;
  localparam int SW_COND_HI = 35;
  localparam int SW_PM_LO = 36;
  localparam int SW_PM_HI = 39;
  localparam int SW_IA_LO = 40;
  localparam int SW_IA_HI = 63;
  // Interrupt levels, index 0 has the highest priority.
  localparam int NLVL = 15;
  localparam logic [3:0] LVL_MC = 4'h0;
  localparam logic [3:0] LVL_PX = 4'h1;
  localparam logic [3:0] LVL_PA = 4'h3;
  localparam logic [3:0] LVL_IO0 = 4'h6;
  // System mask bit per level; MASK_NONE marks a level without one.
  localparam logic [3:0] MASK_NONE = 4'hf;
  localparam logic [3:0] LVL_MASKBIT [0:14] = '{4'h1, 4'h0, 4'hf, 4'hf, 4'h2, 4'h3, 4'h4, 4'h5,
                                                4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc};
  // Low storage layout.
  localparam logic [23:0] OLD_BASE = 24'h000100;
  localparam logic [23:0] NEW_OFS = 24'h000008;
  localparam logic [23:0] RELOC_BASE = 24'h000200;
  localparam logic [23:0] TRACE_STEP = 24'h000008;
  localparam int LVL_SHIFT = 4;
  localparam int KEY_SHIFT = 3;
  localparam logic [7:0] MON_CODE = 8'h01;
  localparam logic [7:0] BE_ALL = 8'hff;
  localparam logic [7:0] BE_NO_MX = 8'hef;
  // Register byte offsets and control bits.
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_NEWHI = 5'h04;
  localparam logic [4:0] REG_NEWLO = 5'h08;
  localparam logic [4:0] REG_SWHI = 5'h0c;
  localparam logic [4:0] REG_SWLO = 5'h10;
  localparam logic [4:0] REG_STAT = 5'h14;
  localparam logic [4:0] REG_TRACE = 5'h18;
  localparam logic [4:0] REG_RELOC = 5'h1c;
  localparam int CTRL_LOAD = 0;
  localparam int CTRL_REL = 1;
  typedef enum logic [1:0] {END_COMPLETE, END_SUPPRESS, END_TERMINATE} pies_end_t;
  typedef enum logic [2:0] {ST_RUN, ST_DECIDE, ST_TRACE, ST_STORE, ST_LOADNEW, ST_LOADREL} pies_st_t;
  // Report of one finished instruction from the execution unit.
  typedef struct packed {
    logic done;
    pies_end_t kind;
    logic [1:0] len;
    logic condWe;
    logic [1:0] condCode;
    logic brTaken;
    logic [23:0] target;
    logic [0:3] pgmExc;
    logic pxReq;
    logic [7:0] code;
  } pies_exec_t;
  // Main storage request, held until acknowledged.
  typedef struct packed {
    logic req;
    logic we;
    logic [7:0] be;
    logic [23:0] addr;
    logic [0:63] wdata;
  } pies_mem_t;
endpackage
`default_nettype wire

// ==== pies_storage_model.sv ====
/*
  Behavioural main storage and channel side for the entry sequencer bench.
  Assumes the pies_pkg storage carrier and one clock shared with the design.
*/
`timescale 1ns/1ps
`default_nettype none
module pies_storage_model
  import pies_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire pies_mem_t memOut,
  input wire logic [3:0] delay,
  output logic [0:63] memRdata,
  output logic memAck
);
  // Sparse word store; the bench preloads it as the channels would.
  logic [0:63] mem [logic [23:0]];
  // Every finished access as {we, addr}, in order.
  logic [24:0] accLog [$];
  // Idle cycles already spent on the open request.
  logic [3:0] waitCnt;

  // One request at a time, acknowledged after delay extra cycles.
  // Outside an ack the data lines toggle, so stale data never looks valid.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      memAck <= 1'b0;
      waitCnt <= 4'h0;
      memRdata <= 64'h0;
    end else if (memOut.req && !memAck && waitCnt == delay) begin
      memAck <= 1'b1;
      waitCnt <= 4'h0;
      accLog.push_back({memOut.we, memOut.addr});
      for (int i = 0; i < 8; i++) begin
        if (memOut.we && memOut.be[7-i]) begin
          mem[memOut.addr][8*i +: 8] = memOut.wdata[8*i +: 8];
        end
      end
      if (!memOut.we) begin
        memRdata <= mem[memOut.addr];
      end
    end else begin
      memAck <= 1'b0;
      waitCnt <= (memOut.req && !memAck) ? waitCnt + 4'h1 : 4'h0;
      memRdata <= ~memRdata;
    end
  end
endmodule
`default_nettype wire
